// ### verilog/lgrb_pkg.sv
// lgrb_pkg: constants, types and carriers for the regulator and pin register bank.
// assumes a single 40 MHz device clock and an external serial engine that issues register strobes.
package lgrb_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] LGRB_ADDR_REG_CTRL = 8'h0E;
   localparam logic [7:0] LGRB_ADDR_PIN_IRQ = 8'h0F;
   localparam logic [7:0] LGRB_ADDR_PIN_DIR_VAL = 8'h10;
   localparam logic [7:0] LGRB_RST_REG_CTRL = 8'h88;
   localparam logic [7:0] LGRB_RST_PIN_IRQ = 8'h00;
   localparam logic [7:0] LGRB_RST_PIN_DIR_VAL = 8'h00;
   localparam logic [7:0] LGRB_RD_UNMAPPED = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int LGRB_TWO_ON_BIT = 7;
   localparam int LGRB_TWO_SLEEP_OFF_BIT = 6;
   localparam int LGRB_TWO_VSEL_LSB = 4;
   localparam int LGRB_ONE_ON_BIT = 3;
   localparam int LGRB_ONE_SLEEP_OFF_BIT = 2;
   localparam int LGRB_ONE_VSEL_LSB = 0;
   localparam int LGRB_HI_NIBBLE_LSB = 4;
   localparam int LGRB_LO_NIBBLE_LSB = 0;
   localparam int LGRB_PINS = 4;

   // ----------------------------------------
   // regulator voltage codes
   // ----------------------------------------
   localparam logic [1:0] LGRB_TWO_V1P8 = 2'h0;
   localparam logic [1:0] LGRB_TWO_V2P5 = 2'h1;
   localparam logic [1:0] LGRB_TWO_V3P0 = 2'h2;
   localparam logic [1:0] LGRB_TWO_V3P3 = 2'h3;
   localparam logic [1:0] LGRB_ONE_VEXT = 2'h0;
   localparam logic [1:0] LGRB_ONE_V2P5 = 2'h1;
   localparam logic [1:0] LGRB_ONE_V2P75 = 2'h2;
   localparam logic [1:0] LGRB_ONE_V3P0 = 2'h3;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LGRB_REG_OFF = 2'b00,
      LGRB_REG_REDUCED = 2'b01,
      LGRB_REG_FULL = 2'b10
   } lgrb_reg_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lgrb_req_s;

   typedef struct packed {
      lgrb_reg_state_e state;
      logic [1:0] voltage_sel;
   } lgrb_reg_out_s;
endpackage

// ### verilog/lgrb_bank.sv
// lgrb_bank: three 8-bit registers steering two regulators and four open-drain pins.
// assumes the serial engine presents one-cycle rd/wr strobes on the device clock.
`timescale 1ns/1ps

// Behaviour
// - regulator control reads 0x88 after reset: both on, sleep-off clear, voltages zero
// - voltage field written while off or with enable is applied on that write
// - regulator two: off if disabled, full in normal, low-power reduced or off
// - regulator one follows the same state table from bits 3 and 2
// - regulator two voltage bits 5:4 select 1.8, 2.5, 3.0, 3.3 V, default 00
// - regulator one voltage bits 1:0 select external, 2.5, 2.75, 3.0 V
// - edge-select bits 7:4: 0 falling edge, 1 rising edge interrupt
// - mask bits 3:0 suppress the pin interrupt when 1, reset unmasked
// - direction bits 7:4: 0 input, 1 output; all inputs after reset
// - output pin with value 1 turns pull-down on, pin driven low
// - output pin with value 0 releases pull-down, pin floats high
// - input pin value bit reads the sampled pin level
// - host writes to value bits of input pins are ignored
// - registers at 0x0E, 0x0F, 0x10, all 8-bit read/write
// - low-power mode needs request pin high, allow set, low-power selected
module lgrb_bank
   import lgrb_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire lgrb_req_s req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic low_power_request_pin,
   input wire logic low_power_allow,
   input wire logic low_power_select,
   output lgrb_reg_out_s regulator_one,
   output lgrb_reg_out_s regulator_two,
   output logic low_power_active,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe,
   output logic [3:0] gpio_event
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] reg_ctrl_reg, reg_ctrl_next;
   logic [7:0] pin_irq_reg, pin_irq_next;
   logic [3:0] dir_reg, dir_next;
   logic [3:0] val_reg, val_next;
   logic [7:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic [3:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic lp_meta_reg, lp_sync_reg;
   logic [3:0] event_reg, event_next;
   logic [3:0] pin_view;

   function automatic lgrb_reg_state_e reg_state(input logic on, input logic sleep_off, input logic lp);
      if (!on)
         reg_state = LGRB_REG_OFF;
      else if (!lp)
         reg_state = LGRB_REG_FULL;
      else if (sleep_off)
         reg_state = LGRB_REG_OFF;
      else
         reg_state = LGRB_REG_REDUCED;
   endfunction

   // ----------------------------------------
   // pin and low-power synchronisers
   // ----------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         // pins idle high on their pull-ups: reset to that level so release makes no false edge
         pin_meta_reg <= 4'hF;
         pin_sync_reg <= 4'hF;
         pin_prev_reg <= 4'hF;
         lp_meta_reg <= 1'b0;
         lp_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= gpio_in;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
         lp_meta_reg <= low_power_request_pin;
         lp_sync_reg <= lp_meta_reg;
      end
   end

   // low-power mode only when the pin asks, allow is set and wait mode is not chosen
   assign low_power_active = lp_sync_reg & low_power_allow & low_power_select;

   // ----------------------------------------
   // register next values
   // ----------------------------------------
   // value bits of input pins show the pin, not the stored bit
   assign pin_view = (dir_reg & val_reg) | (~dir_reg & pin_sync_reg);

   always_comb begin
      reg_ctrl_next = reg_ctrl_reg;
      pin_irq_next = pin_irq_reg;
      dir_next = dir_reg;
      val_next = val_reg;
      rd_data_next = rd_data_reg;
      rd_valid_next = req.rd;
      if (req.wr) begin
         case (req.addr)
            LGRB_ADDR_REG_CTRL: reg_ctrl_next = req.wdata;
            LGRB_ADDR_PIN_IRQ: pin_irq_next = req.wdata;
            LGRB_ADDR_PIN_DIR_VAL: begin
               dir_next = req.wdata[LGRB_HI_NIBBLE_LSB +: LGRB_PINS];
               // only pins already outputs take the written value
               val_next = (dir_reg & req.wdata[LGRB_LO_NIBBLE_LSB +: LGRB_PINS]) | (~dir_reg & val_reg);
            end
            default: ;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            LGRB_ADDR_REG_CTRL: rd_data_next = reg_ctrl_reg;
            LGRB_ADDR_PIN_IRQ: rd_data_next = pin_irq_reg;
            LGRB_ADDR_PIN_DIR_VAL: rd_data_next = {dir_reg, pin_view};
            default: rd_data_next = LGRB_RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_ctrl_reg <= LGRB_RST_REG_CTRL;
         pin_irq_reg <= LGRB_RST_PIN_IRQ;
         dir_reg <= LGRB_RST_PIN_DIR_VAL[LGRB_HI_NIBBLE_LSB +: LGRB_PINS];
         val_reg <= LGRB_RST_PIN_DIR_VAL[LGRB_LO_NIBBLE_LSB +: LGRB_PINS];
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         reg_ctrl_reg <= reg_ctrl_next;
         pin_irq_reg <= pin_irq_next;
         dir_reg <= dir_next;
         val_reg <= val_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;

   // ----------------------------------------
   // regulator outputs
   // ----------------------------------------
   always_comb begin
      regulator_two.state = reg_state(reg_ctrl_reg[LGRB_TWO_ON_BIT], reg_ctrl_reg[LGRB_TWO_SLEEP_OFF_BIT],
                                      low_power_active);
      regulator_two.voltage_sel = reg_ctrl_reg[LGRB_TWO_VSEL_LSB +: 2];
      regulator_one.state = reg_state(reg_ctrl_reg[LGRB_ONE_ON_BIT], reg_ctrl_reg[LGRB_ONE_SLEEP_OFF_BIT],
                                      low_power_active);
      regulator_one.voltage_sel = reg_ctrl_reg[LGRB_ONE_VSEL_LSB +: 2];
   end

   // ----------------------------------------
   // open-drain pins and edge events
   // ----------------------------------------
   assign gpio_out = 4'h0;
   assign gpio_oe = dir_reg & val_reg;

   genvar g;
   generate
      for (g = 0; g < LGRB_PINS; g++) begin : g_edge
         logic rise, fall, hit;
         assign rise = pin_sync_reg[g] & ~pin_prev_reg[g];
         assign fall = ~pin_sync_reg[g] & pin_prev_reg[g];
         // edge select picks rise or fall; outputs and masked pins stay quiet
         assign hit = pin_irq_reg[LGRB_HI_NIBBLE_LSB + g] ? rise : fall;
         assign event_next[g] = hit & ~pin_irq_reg[LGRB_LO_NIBBLE_LSB + g] & ~dir_reg[g];
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         event_reg <= 4'h0;
      else
         event_reg <= event_next;
   end

   assign gpio_event = event_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_ctrl_reset_value: assert property (@(posedge clock) $rose(reset_n) |-> reg_ctrl_reg == LGRB_RST_REG_CTRL)
      else $error("regulator control not 0x88 after reset");
   a_volt_applied: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && req.addr == LGRB_ADDR_REG_CTRL |=> regulator_two.voltage_sel == $past(req.wdata[5:4])
      && regulator_one.voltage_sel == $past(req.wdata[1:0]))
      else $error("written voltage code not applied");
   a_two_state_map: assert property (@(posedge clock) disable iff (!reset_n)
      regulator_two.state == (!reg_ctrl_reg[7] ? LGRB_REG_OFF : !low_power_active ? LGRB_REG_FULL
      : reg_ctrl_reg[6] ? LGRB_REG_OFF : LGRB_REG_REDUCED))
      else $error("regulator two state wrong");
   a_one_off_disabled: assert property (@(posedge clock) disable iff (!reset_n)
      !reg_ctrl_reg[3] |-> regulator_one.state == LGRB_REG_OFF)
      else $error("regulator one on while disabled");
   a_one_lp_sleep: assert property (@(posedge clock) disable iff (!reset_n)
      reg_ctrl_reg[3:2] == 2'b11 && low_power_active |-> regulator_one.state == LGRB_REG_OFF)
      else $error("regulator one not off in low power");
   a_lp_from_pin: assert property (@(posedge clock) disable iff (!reset_n)
      low_power_request_pin && low_power_allow && low_power_select ##1 $stable(low_power_allow && low_power_select)
      ##1 $stable(low_power_allow && low_power_select) |-> low_power_active)
      else $error("low-power mode not entered two cycles after request");
   a_drive_low: assert property (@(posedge clock) disable iff (!reset_n)
      gpio_oe != 4'h0 |-> (gpio_oe & ~dir_reg) == 4'h0 && gpio_out == 4'h0)
      else $error("pin driven while input or driven high");
   a_release_high: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && req.addr == LGRB_ADDR_PIN_DIR_VAL && req.wdata[7:4] == 4'hF && req.wdata[3:0] == 4'h0
      && dir_reg == 4'hF |=> gpio_oe == 4'h0)
      else $error("pull-down not released");
   a_input_write_ignored: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && req.addr == LGRB_ADDR_PIN_DIR_VAL && dir_reg == 4'h0 |=> val_reg == $past(val_reg))
      else $error("write to input value bit took effect");
   a_input_readback: assert property (@(posedge clock) disable iff (!reset_n)
      req.rd && req.addr == LGRB_ADDR_PIN_DIR_VAL && dir_reg == 4'h0 |=> rd_valid
      && rd_data[3:0] == $past(pin_sync_reg))
      else $error("input value bits not pin level");
   a_rise_event: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(pin_sync_reg[0]) && pin_irq_reg[4] && !pin_irq_reg[0] && !dir_reg[0] |=> gpio_event[0])
      else $error("rising edge event missing");
   a_masked_quiet: assert property (@(posedge clock) disable iff (!reset_n)
      $past(pin_irq_reg[3:0] | dir_reg) != 4'h0 |-> (gpio_event & $past(pin_irq_reg[3:0] | dir_reg)) == 4'h0)
      else $error("event from masked or output pin");
   a_event_single: assert property (@(posedge clock) disable iff (!reset_n)
      gpio_event[1] |=> !gpio_event[1])
      else $error("event longer than one cycle");
   a_unmapped_zero: assert property (@(posedge clock) disable iff (!reset_n)
      req.rd && req.addr > LGRB_ADDR_PIN_DIR_VAL |=> rd_data == LGRB_RD_UNMAPPED)
      else $error("unmapped read not zero");

   c_low_power_reduced: cover property (@(posedge clock) disable iff (!reset_n)
      regulator_two.state == LGRB_REG_REDUCED);
   c_pin_event: cover property (@(posedge clock) disable iff (!reset_n) gpio_event != 4'h0);
   c_pin_driven: cover property (@(posedge clock) disable iff (!reset_n) gpio_oe == 4'hF);
endmodule // lgrb_bank

// ### testbench/lgrb_host_model.sv
// lgrb_host_model: register host on the strobe port, one request at a time.
// assumes the bank takes a strobe at a rising edge and answers a read one cycle later.
`timescale 1ns/1ps
module lgrb_host_model
   import lgrb_pkg::*;
(
   input wire logic clock,
   output lgrb_req_s req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   // ----------------------------------------
   // request tasks
   // ----------------------------------------
   // idle bus shows inverted leftovers, so a stale copy can never pass for a request
   initial req = '0;

   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock);
      #2 req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clock);
      #2 req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask

   task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge clock);
      #2 req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h5A};
      @(posedge clock);
      #2 req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hA5};
      ok = 1'b0;
      data = 8'h00;
      // bounded wait: a lost answer shows up as ok low
      for (int n = 0; n < 4 && !ok; n++) begin
         if (rd_valid === 1'b1) begin
            ok = 1'b1;
            data = rd_data;
         end else begin
            @(posedge clock);
            #2;
         end
      end
   endtask
endmodule // lgrb_host_model

// ### testbench/testbench.sv
// testbench: self-checking bench for lgrb_bank against a behavioural register model.
// assumes lgrb_pkg and lgrb_host_model are compiled first; pins carry external pull-ups.
`timescale 1ns/1ps
module testbench;
   import lgrb_pkg::*;
   logic clock;
   logic reset_n = 1'b0;
   lgrb_req_s req;
   logic [7:0] rd_data;
   logic rd_valid;
   logic lp_pin = 1'b0;
   logic lp_allow = 1'b0;
   logic lp_sel = 1'b0;
   logic lp_act;
   lgrb_reg_out_s reg_one, reg_two;
   logic [3:0] ext_lvl = 4'hF;
   logic [3:0] pad, gpio_out, gpio_oe, gpio_event;
   logic [7:0] m_reg[3] = '{8'h88, 8'h00, 8'h00};
   logic [7:0] c;
   int bad_count = 0;
   int tests_run = 0;
   int seed = 77623;
   int ev_cnt[4];

   // ----------------------------------------
   // clock, pins, instances
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // open drain: a released pin follows the external level, pulled up when idle
   assign pad = ~gpio_oe & ext_lvl;
   // counted on the falling edge, away from the edge that launches the pulse
   always @(negedge clock) begin
      for (int i = 0; i < 4; i++) ev_cnt[i] += (gpio_event[i] === 1'b1);
   end
   lgrb_host_model host (.clock(clock), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));
   lgrb_bank uut (.clock(clock), .reset_n(reset_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
      .low_power_request_pin(lp_pin), .low_power_allow(lp_allow), .low_power_select(lp_sel),
      .regulator_one(reg_one), .regulator_two(reg_two), .low_power_active(lp_act),
      .gpio_in(pad), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_event(gpio_event));

   // ----------------------------------------
   // model and checks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   function automatic logic [3:0] exp_reg(input logic [3:0] f, input logic lp);
      lgrb_reg_state_e st;
      st = !f[3] ? LGRB_REG_OFF : !lp ? LGRB_REG_FULL : f[2] ? LGRB_REG_OFF : LGRB_REG_REDUCED;
      return {st, f[1:0]};
   endfunction

   task automatic check_all();
      logic [7:0] rv;
      logic [7:0] ev;
      logic ok;
      logic lp;
      lp = lp_pin & lp_allow & lp_sel;
      check("lp_active", {7'h0, lp_act}, {7'h0, lp});
      check("reg_two", {4'h0, reg_two}, {4'h0, exp_reg(m_reg[0][7:4], lp)});
      check("reg_one", {4'h0, reg_one}, {4'h0, exp_reg(m_reg[0][3:0], lp)});
      check("pin_oe", {4'h0, gpio_oe}, {4'h0, m_reg[2][7:4] & m_reg[2][3:0]});
      check("pin_out", {4'h0, gpio_out}, 8'h00);
      for (int a = 0; a < 4; a++) begin
         host.read(LGRB_ADDR_REG_CTRL + 8'(a), rv, ok);
         check("read_done", {7'h0, ok}, 8'h01);
         if (ok !== 1'b1) summarize();
         ev = (a == 3) ? LGRB_RD_UNMAPPED : m_reg[a[1:0]];
         if (a == 2) ev[3:0] = (m_reg[2][7:4] & m_reg[2][3:0]) | (~m_reg[2][7:4] & ext_lvl);
         check("readback", rv, ev);
      end
   endtask

   // voltage moves only while off, enable comes last
   task automatic ctrl_write(input logic [7:0] v);
      host.write(LGRB_ADDR_REG_CTRL, m_reg[0] & 8'h77);
      host.write(LGRB_ADDR_REG_CTRL, v & 8'h77);
      host.write(LGRB_ADDR_REG_CTRL, v);
      m_reg[0] = v;
   endtask

   // direction first with stored values, so a pin turning output never depends on ordering
   task automatic pin_write(input logic [3:0] d, input logic [3:0] v);
      host.write(LGRB_ADDR_PIN_DIR_VAL, {d, m_reg[2][3:0]});
      m_reg[2][7:4] = d;
      host.write(LGRB_ADDR_PIN_DIR_VAL, {d, v});
      m_reg[2][3:0] = (d & v) | (~d & m_reg[2][3:0]);
   endtask

   task automatic edge_step(input logic [3:0] nl);
      logic [3:0] exp;
      exp = (ext_lvl ^ nl) & ~m_reg[2][7:4] & ~m_reg[1][3:0] & ~(m_reg[1][7:4] ^ nl);
      ev_cnt = '{default: 0};
      ext_lvl = nl;
      wait_n(6);
      for (int i = 0; i < 4; i++) check("events", 8'(ev_cnt[i]), {7'h0, exp[i]});
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clock);
      #2 reset_n = 1'b1;
      check_all();
      host.write(8'h11, 8'hFF);
      check_all();
      pin_write(4'hF, 4'hF);
      check_all();
      pin_write(4'hF, 4'h0);
      check_all();
      repeat (20) begin
         ctrl_write(8'($random(seed)));
         {lp_pin, lp_allow, lp_sel} = 3'($random(seed));
         pin_write(4'($random(seed)), 4'($random(seed)));
         ext_lvl = 4'($random(seed));
         wait_n(3);
         check_all();
      end
      repeat (20) begin
         c = 8'($random(seed));
         host.write(LGRB_ADDR_PIN_IRQ, c);
         m_reg[1] = c;
         pin_write(4'($random(seed)), 4'h0);
         wait_n(6);
         edge_step(4'($random(seed)));
         edge_step(~ext_lvl);
      end
      check_all();
      lp_pin = 1'b0;
      reset_n = 1'b0;
      m_reg = '{8'h88, 8'h00, 8'h00};
      wait_n(2);
      reset_n = 1'b1;
      wait_n(1);
      check_all();
      summarize();
   end
endmodule // testbench
